// [common/tap_consts.svh]
// Purpose: constants of the sram boundary scan test access port
// Assumes: one instruction register of three bits, 89 boundary cells
// Notes: cell 89 (index 88) is the output bus enable cell
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// ----------------------------------------------------------------
// register sizes
// ----------------------------------------------------------------
`define IR_LEN 3
`define ID_LEN 32
`define BSR_LEN 89
`define RING_LEN 88
`define OE_CELL 88

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define INSTR_EXTEST 3'h0
`define INSTR_IDCODE 3'h1
`define INSTR_SAMPLE_Z 3'h2
`define INSTR_PRELOAD 3'h4
`define INSTR_BYPASS 3'h7
`define IR_CAPTURE 3'h1

// ----------------------------------------------------------------
// identification code fields
// ----------------------------------------------------------------
`define ID_REVISION 3'h0
`define ID_DEPTH 5'h0B
`define ID_ARCH 6'h08
`define ID_WIDTH 6'h27
// vendor code value is arbitrary
`define ID_VENDOR 11'h155
`define ID_PRESENT 1'h1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define UPD_RESET {1'h1, 88'h0}
`define TCK_MAX_MHZ 20

`endif

// [common/tap_pkg.sv]
// Purpose: types of the sram boundary scan test access port
// Assumes: constants come from tap_consts.svh
// Notes: none
`include "tap_consts.svh"

package tap_pkg;

    // ----------------------------------------------------------------
    // controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } state_type;

    // ----------------------------------------------------------------
    // selected data chain
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CH_BYPASS, CH_IDCODE, CH_BOUNDARY
    } chain_type;

    // ----------------------------------------------------------------
    // drive state handed to the sram clock domain
    // ----------------------------------------------------------------
    typedef struct packed {
        logic extest;
        logic hiz;
        logic [`RING_LEN-1:0] cells;
    } drive_type;

endpackage : tap_pkg

// [verilog/tap_sync.sv]
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second
`timescale 1ns/1ps

module tap_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    always_comb begin
        meta_nxt = rst_n ? d : '0;
        q_nxt = rst_n ? meta_r : '0;
    end

    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        q <= q_nxt;
    end

endmodule : tap_sync

// [verilog/tap_fsm.sv]
// Purpose: sixteen-state test access port controller
// Assumes: tms comes from the test clock domain
// Notes: held in test-logic-reset while rst_n is low
`timescale 1ns/1ps

module tap_fsm (
    input wire logic test_clock,
    input wire logic rst_n,
    input wire logic tms,
    output tap_pkg::state_type state
);

    tap_pkg::state_type state_nxt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state;
        case (state)
            tap_pkg::TLR: state_nxt = tms ? tap_pkg::TLR : tap_pkg::RTI;
            tap_pkg::RTI: state_nxt = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: state_nxt = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: state_nxt = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR: state_nxt = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR: state_nxt = tms ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
            tap_pkg::PA_DR: state_nxt = tms ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
            tap_pkg::EX2_DR: state_nxt = tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::UPD_DR: state_nxt = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_IR: state_nxt = tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: state_nxt = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR: state_nxt = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR: state_nxt = tms ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
            tap_pkg::PA_IR: state_nxt = tms ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
            tap_pkg::EX2_IR: state_nxt = tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            tap_pkg::UPD_IR: state_nxt = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            default: state_nxt = tap_pkg::TLR;
        endcase
        if (!rst_n) begin
            state_nxt = tap_pkg::TLR;
        end
    end

    always_ff @(posedge test_clock) begin
        state <= state_nxt;
    end

endmodule : tap_fsm

// [verilog/sram_boundary_scan_tap.sv]
// Purpose: boundary scan test logic of a pipelined synchronous sram
// Assumes: test_clock is unrelated to clock; ring_in and nrst are pins
// Notes: scan logic runs on test_clock, output control on clock
`timescale 1ns/1ps
`include "tap_consts.svh"

module sram_boundary_scan_tap (
    input wire logic clock,
    input wire logic nrst,
    input wire logic test_clock,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`RING_LEN-1:0] ring_in,
    output logic test_mode,
    output logic out_hiz,
    output logic [`RING_LEN-1:0] test_out_value
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic rst_tck_n;
    logic [`RING_LEN-1:0] ring_s;
    tap_pkg::state_type state;
    tap_pkg::chain_type sel;
    tap_pkg::chain_type sel_out;

    logic [`IR_LEN-1:0] ir_r;
    logic [`IR_LEN-1:0] ir_nxt;
    logic [`IR_LEN-1:0] ir_sh_r;
    logic [`IR_LEN-1:0] ir_sh_nxt;
    logic bypass_r;
    logic bypass_nxt;
    logic [`ID_LEN-1:0] id_sh_r;
    logic [`ID_LEN-1:0] id_sh_nxt;
    logic [`BSR_LEN-1:0] bsr_r;
    logic [`BSR_LEN-1:0] bsr_nxt;
    logic [`BSR_LEN-1:0] upd_r;
    logic [`BSR_LEN-1:0] upd_nxt;

    tap_pkg::drive_type drv_cur;
    tap_pkg::drive_type drv_r;
    tap_pkg::drive_type drv_nxt;
    logic tog_r;
    logic tog_nxt;

    logic tdo_nxt;
    logic tdo_oe_nxt;

    logic tog_s;
    logic seen_r;
    logic seen_nxt;
    tap_pkg::drive_type out_r;
    tap_pkg::drive_type out_nxt;

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    function automatic tap_pkg::chain_type chain_of(input logic [`IR_LEN-1:0] code);
        tap_pkg::chain_type ch;
        ch = tap_pkg::CH_BYPASS;
        case (code)
            `INSTR_IDCODE: ch = tap_pkg::CH_IDCODE;
            `INSTR_EXTEST: ch = tap_pkg::CH_BOUNDARY;
            `INSTR_SAMPLE_Z: ch = tap_pkg::CH_BOUNDARY;
            `INSTR_PRELOAD: ch = tap_pkg::CH_BOUNDARY;
            `INSTR_BYPASS: ch = tap_pkg::CH_BYPASS;
            default: ch = tap_pkg::CH_BYPASS;
        endcase
        return ch;
    endfunction : chain_of

    // ----------------------------------------------------------------
    // synchronisers into the test clock domain
    // ----------------------------------------------------------------
    tap_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .clk(test_clock),
        .rst_n(1'h1),
        .d(nrst),
        .q(rst_tck_n)
    );

    tap_sync #(
        .WIDTH(`RING_LEN)
    ) u_ring_sync (
        .clk(test_clock),
        .rst_n(rst_tck_n),
        .d(ring_in),
        .q(ring_s)
    );

    // ----------------------------------------------------------------
    // controller
    // ----------------------------------------------------------------
    tap_fsm u_fsm (
        .test_clock(test_clock),
        .rst_n(rst_tck_n),
        .tms(tms),
        .state(state)
    );

    // ----------------------------------------------------------------
    // scan registers, rising test clock
    // ----------------------------------------------------------------
    always_comb begin
        ir_nxt = ir_r;
        ir_sh_nxt = ir_sh_r;
        bypass_nxt = bypass_r;
        id_sh_nxt = id_sh_r;
        bsr_nxt = bsr_r;
        upd_nxt = upd_r;
        sel = chain_of(ir_r);
        case (state)
            tap_pkg::TLR: begin
                ir_nxt = `INSTR_IDCODE;
                upd_nxt = `UPD_RESET;
            end
            tap_pkg::CAP_IR: begin
                ir_sh_nxt = `IR_CAPTURE;
            end
            tap_pkg::SH_IR: begin
                ir_sh_nxt = {tdi, ir_sh_r[`IR_LEN-1:1]};
            end
            tap_pkg::UPD_IR: begin
                ir_nxt = ir_sh_r;
            end
            tap_pkg::CAP_DR: begin
                case (sel)
                    tap_pkg::CH_BYPASS: bypass_nxt = 1'h0;
                    tap_pkg::CH_IDCODE: begin
                        id_sh_nxt = {`ID_REVISION, `ID_DEPTH, `ID_ARCH,
                            `ID_WIDTH, `ID_VENDOR, `ID_PRESENT};
                    end
                    tap_pkg::CH_BOUNDARY: begin
                        bsr_nxt = {upd_r[`OE_CELL], ring_s};
                    end
                    default: bypass_nxt = 1'h0;
                endcase
            end
            tap_pkg::SH_DR: begin
                case (sel)
                    tap_pkg::CH_BYPASS: bypass_nxt = tdi;
                    tap_pkg::CH_IDCODE: begin
                        id_sh_nxt = {tdi, id_sh_r[`ID_LEN-1:1]};
                    end
                    tap_pkg::CH_BOUNDARY: begin
                        bsr_nxt = {tdi, bsr_r[`BSR_LEN-1:1]};
                    end
                    default: bypass_nxt = tdi;
                endcase
            end
            tap_pkg::UPD_DR: begin
                if (sel == tap_pkg::CH_BOUNDARY) begin
                    upd_nxt = bsr_r;
                end
            end
            default: begin
                ir_nxt = ir_r;
            end
        endcase
    end

    always_ff @(posedge test_clock) begin
        if (!rst_tck_n) begin
            ir_r <= `INSTR_IDCODE;
            ir_sh_r <= `IR_CAPTURE;
            bypass_r <= 1'h0;
            id_sh_r <= '0;
            bsr_r <= '0;
            upd_r <= `UPD_RESET;
        end else begin
            ir_r <= ir_nxt;
            ir_sh_r <= ir_sh_nxt;
            bypass_r <= bypass_nxt;
            id_sh_r <= id_sh_nxt;
            bsr_r <= bsr_nxt;
            upd_r <= upd_nxt;
        end
    end

    // ----------------------------------------------------------------
    // output control, handed over by toggle
    // ----------------------------------------------------------------
    always_comb begin
        drv_cur.extest = (ir_r == `INSTR_EXTEST);
        drv_cur.hiz = (ir_r == `INSTR_SAMPLE_Z)
            | (drv_cur.extest & ~upd_r[`OE_CELL]);
        drv_cur.cells = upd_r[`RING_LEN-1:0];
        drv_nxt = drv_r;
        tog_nxt = tog_r;
        if (drv_cur != drv_r) begin
            drv_nxt = drv_cur;
            tog_nxt = ~tog_r;
        end
    end

    always_ff @(posedge test_clock) begin
        if (!rst_tck_n) begin
            drv_r <= {1'h0, 1'h0, 88'h0};
            tog_r <= 1'h0;
        end else begin
            drv_r <= drv_nxt;
            tog_r <= tog_nxt;
        end
    end

    // ----------------------------------------------------------------
    // serial output, falling test clock
    // ----------------------------------------------------------------
    always_comb begin
        sel_out = chain_of(ir_r);
        tdo_nxt = 1'h0;
        tdo_oe_nxt = 1'h0;
        if (state == tap_pkg::SH_IR) begin
            tdo_nxt = ir_sh_r[0];
            tdo_oe_nxt = 1'h1;
        end else if (state == tap_pkg::SH_DR) begin
            tdo_oe_nxt = 1'h1;
            case (sel_out)
                tap_pkg::CH_BYPASS: tdo_nxt = bypass_r;
                tap_pkg::CH_IDCODE: tdo_nxt = id_sh_r[0];
                tap_pkg::CH_BOUNDARY: tdo_nxt = bsr_r[0];
                default: tdo_nxt = bypass_r;
            endcase
        end
    end

    always_ff @(negedge test_clock) begin
        if (!rst_tck_n) begin
            tdo <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo <= tdo_nxt;
            tdo_oe <= tdo_oe_nxt;
        end
    end

    // ----------------------------------------------------------------
    // sram clock domain
    // ----------------------------------------------------------------
    tap_sync #(
        .WIDTH(1)
    ) u_tog_sync (
        .clk(clock),
        .rst_n(nrst),
        .d(tog_r),
        .q(tog_s)
    );

    always_comb begin
        seen_nxt = tog_s;
        out_nxt = out_r;
        if (tog_s != seen_r) begin
            out_nxt = drv_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            seen_r <= 1'h0;
            out_r <= {1'h0, 1'h0, 88'h0};
        end else begin
            seen_r <= seen_nxt;
            out_r <= out_nxt;
        end
    end

    assign test_mode = out_r.extest;
    assign out_hiz = out_r.hiz;
    assign test_out_value = out_r.cells;

endmodule : sram_boundary_scan_tap

// [verif/tap_tester.sv]
// Purpose: model of the external boundary scan tester
// Assumes: the test clock stands still between operations
// Notes: a released tdo reads as the inverse of its last level
`timescale 1ns/1ps

module tap_tester (
    output logic test_clock,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic line_r;

    initial begin
        test_clock = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        line_r = 1'b0;
    end

    // ----------------------------------------------------------------
    // one test clock period, tdo read just before the rising edge
    // ----------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #6;
        q = tdo_oe ? tdo : ~line_r;
        line_r = q;
        #1.5 test_clock = 1'b1;
        #7.5 test_clock = 1'b0;
    endtask : step

    task automatic hold(input logic m, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(m, 1'b1, q);
        end
    endtask : hold

    // one ir or dr scan of n bits from idle, back to idle
    task automatic scan(input logic ir, input int n, input logic [88:0] din,
                        output logic [88:0] dout);
        logic q;
        dout = '0;
        step(1'b0, 1'b1, q);
        step(1'b1, 1'b1, q);
        if (ir) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        hold(1'b0, 7);
    endtask : scan
endmodule : tap_tester

// [verif/sram_boundary_scan_tap_chk.sv]
// Purpose: port checks of the boundary scan test port
// Assumes: tms runs its reset pattern right after nrst is released
// Notes: keeps its own model of the controller and instruction
`timescale 1ns/1ps
`include "tap_consts.svh"

module sram_boundary_scan_tap_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic test_clock,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [`RING_LEN-1:0] ring_in,
    input wire logic test_mode,
    input wire logic out_hiz,
    input wire logic [`RING_LEN-1:0] test_out_value
);
    // next state, one nibble a state, for tms low and high
    localparam logic [63:0] nxt0 = 64'h1BDDBBA146644311;
    localparam logic [63:0] nxt1 = 64'h2FEFCC0287855920;
    logic [3:0] st_r, st_nxt;
    logic [2:0] sh_r, sh_nxt, ir_r, ir_nxt;
    logic [1:0] out_r, out_nxt;

    // ----------------------------------------------------------------
    // controller model
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = tms ? nxt1[st_r*4 +: 4] : nxt0[st_r*4 +: 4];
        sh_nxt = (st_r == 4'hB) ? {tdi, sh_r[2:1]} : sh_r;
        ir_nxt = (st_r == 4'hF) ? sh_r : ir_r;
        out_nxt = {tdo, tdo_oe};
        if (!nrst || st_r == 4'h0) begin
            ir_nxt = `INSTR_IDCODE;
        end
        if (!nrst) begin
            st_nxt = 4'h0;
        end
    end

    always_ff @(posedge test_clock) begin
        st_r <= st_nxt;
        sh_r <= sh_nxt;
        ir_r <= ir_nxt;
        out_r <= out_nxt;
    end

    a_tdo_fall_only: assert property (@(negedge test_clock) disable iff (!nrst)
        {tdo, tdo_oe} == out_r) else $error("tdo moved away from a falling edge");
    a_oe_in_shift: assert property (@(posedge test_clock) disable iff (!nrst)
        tdo_oe == (st_r == 4'h4 || st_r == 4'hB)) else $error("tdo enable off state");
    a_capture_ir_bit: assert property (@(posedge test_clock) disable iff (!nrst)
        $past(st_r) == 4'hA && st_r == 4'hB |-> tdo) else $error("ir capture bit0 not 1");
    a_id_first_bit: assert property (@(posedge test_clock) disable iff (!nrst)
        $past(st_r) == 4'h3 && st_r == 4'h4 && ir_r == `INSTR_IDCODE |-> tdo)
        else $error("id bit0 not 1");
    a_bypass_zero: assert property (@(posedge test_clock) disable iff (!nrst)
        $past(st_r) == 4'h3 && st_r == 4'h4 && ir_r == `INSTR_BYPASS |-> !tdo)
        else $error("bypass capture not 0");
    a_bypass_pass: assert property (@(posedge test_clock) disable iff (!nrst)
        $past(st_r) == 4'h4 && st_r == 4'h4 && ir_r == `INSTR_BYPASS |-> tdo == $past(tdi))
        else $error("bypass not one bit");
    a_tms_reset: assert property (@(posedge test_clock) disable iff (!nrst)
        tms [*8] ##1 tms [*4] |-> !test_mode && !out_hiz) else $error("tms reset failed");
    a_float_hiz: assert property (@(posedge test_clock) disable iff (!nrst)
        (ir_r == `INSTR_SAMPLE_Z) [*5] |-> out_hiz && !test_mode) else $error("float not hiz");
    a_extest_mode: assert property (@(posedge test_clock) disable iff (!nrst)
        (ir_r == `INSTR_EXTEST) [*5] |-> test_mode) else $error("extest mode missing");
    a_reset_outputs: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> !test_mode && !out_hiz && test_out_value == '0)
        else $error("outputs not cleared by reset");
endmodule : sram_boundary_scan_tap_chk

bind sram_boundary_scan_tap sram_boundary_scan_tap_chk chk (.clock(clock), .nrst(nrst),
    .test_clock(test_clock), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .ring_in(ring_in), .test_mode(test_mode), .out_hiz(out_hiz),
    .test_out_value(test_out_value));

// [verif/sram_boundary_scan_tap_bench.sv]
// Purpose: self-checking bench of the boundary scan test port
// Assumes: io ring levels held constant through the run
// Notes: scans are made by the tester model
`timescale 1ns/1ps
`include "tap_consts.svh"

module sram_boundary_scan_tap_bench;
    localparam logic [87:0] pat = 88'hC3A50F961E2D3C4B5A6978;
    localparam logic [87:0] ring = 88'h0123456789ABCDEF012345;
    localparam logic [31:0] id_exp = {`ID_REVISION, `ID_DEPTH, `ID_ARCH, `ID_WIDTH,
                                      `ID_VENDOR, `ID_PRESENT};
    logic clock, nrst, test_clock, tms, tdi, tdo, tdo_oe, test_mode, out_hiz;
    logic [87:0] ring_in, test_out_value;
    logic [88:0] dout;
    int n_fail, n_checks;

    sram_boundary_scan_tap DUT (.clock(clock), .nrst(nrst), .test_clock(test_clock),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in),
        .test_mode(test_mode), .out_hiz(out_hiz), .test_out_value(test_out_value));
    tap_tester tester (.test_clock(test_clock), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [88:0] exp, input logic [88:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic settle;
        repeat (10) @(posedge clock);
    endtask : settle

    task automatic end_sim;
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_idcode;
        tester.scan(1'b0, 32, '0, dout);
        check("idcode", {57'h0, id_exp}, dout);
    endtask : t_idcode

    task automatic t_bypass;
        tester.scan(1'b1, 3, 89'h7, dout);
        check("ir capture", 89'h1, dout);
        tester.scan(1'b0, 4, 89'hB, dout);
        check("bypass", 89'h6, dout);
    endtask : t_bypass

    task automatic t_float;
        tester.scan(1'b1, 3, 89'h2, dout);
        settle();
        check("float mode", 89'h1, {87'h0, test_mode, out_hiz});
        tester.scan(1'b0, 89, {1'b1, pat}, dout);
        check("float capture", {1'b1, ring}, dout);
        tester.scan(1'b1, 3, 89'h7, dout);
        settle();
        check("float ended", 89'h0, {87'h0, test_mode, out_hiz});
    endtask : t_float

    task automatic t_preload_extest;
        tester.scan(1'b1, 3, 89'h4, dout);
        tester.scan(1'b0, 89, {1'b0, pat}, dout);
        check("sample", {1'b1, ring}, dout);
        settle();
        check("sample mode", 89'h0, {87'h0, test_mode, out_hiz});
        tester.scan(1'b1, 3, 89'h0, dout);
        settle();
        check("extest mode", 89'h3, {87'h0, test_mode, out_hiz});
        check("extest value", {1'b0, pat}, {1'b0, test_out_value});
        tester.scan(1'b0, 89, {1'b1, ~pat}, dout);
        check("extest capture", {1'b0, ring}, dout);
        settle();
        check("extest enable", 89'h2, {87'h0, test_mode, out_hiz});
        check("extest new value", {1'b0, ~pat}, {1'b0, test_out_value});
    endtask : t_preload_extest

    task automatic t_tms_reset;
        tester.scan(1'b0, 89, {1'b0, pat}, dout);
        settle();
        check("cell float", 89'h3, {87'h0, test_mode, out_hiz});
        tester.hold(1'b1, 12);
        settle();
        check("reset mode", 89'h0, {87'h0, test_mode, out_hiz});
        check("reset value", 89'h0, {1'b0, test_out_value});
        t_idcode();
        tester.scan(1'b1, 3, 89'h4, dout);
        tester.scan(1'b0, 89, '1, dout);
        check("cell preset", 89'h1, {88'h0, dout[88]});
    endtask : t_tms_reset

    initial begin
        nrst = 1'b0;
        ring_in = ring;
        n_fail = 0;
        n_checks = 0;
        #3.3;
        tester.hold(1'b1, 4);
        @(posedge clock);
        nrst <= 1'b1;
        tester.hold(1'b1, 12);
        t_idcode();
        t_bypass();
        t_float();
        t_preload_extest();
        t_tms_reset();
        end_sim();
    end

    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule : sram_boundary_scan_tap_bench
